// >>> hdl/ars_pkg.sv
// ars_pkg: register map, field layout, reset values and states of the
// adc result sequencer.
// assumes an 8-bit apb byte address, one 32-bit aligned word per register.
package ars_pkg;

    // register byte offsets
    localparam logic [7:0] ARS_OFF_CTL0     = 8'h00; // first control register
    localparam logic [7:0] ARS_OFF_CTL_LAST = 8'h14; // conversion_start_control
    localparam logic [7:0] ARS_OFF_SEQ_CTL  = 8'h0C; // sequence_control
    localparam logic [7:0] ARS_OFF_TRIG_CTL = 8'h08; // trigger control
    localparam logic [7:0] ARS_OFF_STATUS   = 8'h18; // converter_status_zero
    localparam logic [7:0] ARS_OFF_IRQ_STAT = 8'h1C; // sticky events, w1c
    localparam logic [7:0] ARS_OFF_IRQ_MASK = 8'h20; // event mask
    localparam logic [7:0] ARS_OFF_CCF      = 8'h24; // complete flags, w1c
    localparam logic [7:0] ARS_OFF_RESULT   = 8'h40; // first_result_register
    localparam logic [2:0] ARS_RESULT_PAGE  = 3'h2;  // paddr[7:5] of results

    // counts
    localparam int ARS_NUM_CTL     = 6;  // converter control registers
    localparam int ARS_NUM_RESULT  = 8;  // result file depth
    localparam int ARS_CTL_LAST    = 5;  // index of conversion_start_control

    // sequence_control fields
    localparam int ARS_FRZ_LO      = 0;  // freeze_select_low
    localparam int ARS_FRZ_HI      = 1;  // freeze_select_high
    localparam int ARS_FIFO_BIT    = 2;  // fifo mode
    localparam int ARS_LEN_LO      = 3;  // length_bit_one
    localparam int ARS_LEN_TOP     = 6;  // length_bit_eight
    localparam logic [3:0] ARS_LEN_FULL = 4'h8; // conversions for 0 or >= 8

    // freeze_select encodings
    localparam logic [1:0] ARS_FRZ_CONT   = 2'h0; // keep converting
    localparam logic [1:0] ARS_FRZ_RSVD   = 2'h1; // reserved, acts as cont
    localparam logic [1:0] ARS_FRZ_FINISH = 2'h2; // finish then freeze
    localparam logic [1:0] ARS_FRZ_NOW    = 2'h3; // freeze at once

    // other control fields
    localparam int ARS_EXTERNAL_TRIGGER_ENABLE_BIT   = 0;  // external_trigger_enable in ctl2
    localparam int ARS_SCAN_BIT    = 5;  // continuous scan in ctl5

    // status fields
    localparam int ARS_ST_CC_LO    = 0;  // conversion_counter [2:0]
    localparam int ARS_ST_BUSY     = 3;  // sequence active
    localparam int ARS_ST_FROZEN   = 4;  // held by freeze

    // interrupt event bits
    localparam int ARS_EV_SEQ      = 0;  // sequence complete
    localparam int ARS_EV_CONV     = 1;  // one conversion stored
    localparam int ARS_NUM_EV      = 2;

    // reset values
    localparam logic [7:0] ARS_CTL_RST  = 8'h00;
    localparam logic [1:0] ARS_MASK_RST = 2'h0;

    // sequencer states
    typedef enum logic [1:0]
    {
        ARS_IDLE,    // no sequence
        ARS_LAUNCH,  // about to request a conversion
        ARS_CONV     // conversion in the core
    } ars_state_t;

endpackage : ars_pkg

// >>> hdl/ars_adc_result_sequencer.sv
// ars_adc_result_sequencer: apb register file, result placement and
// sequencing logic of a converter; the analog core sits outside.
// assumes the core answers each conv_start with one conv_done pulse and
// pauses while conv_hold is high; all inputs are synchronous to pclk.
// the bus answers with zero wait states; read data is captured in the
// setup cycle, so a register that changes during the access phase shows
// the value it held one cycle earlier.
// Function
// R1: non-fifo: nth result into nth register
// R2: fifo: counter kept across sequence boundaries
// R3: fifo scan: counter wraps to register zero
// R4: conversion counter readable in status field
// R5: abort or control write clears counter
// R6: length code zero or top bit: eight
// R7: freeze field selects breakpoint response
// R8: software uses fifo with scan or trigger
// R9: freeze request input gates freeze behaviour
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none

module ars_adc_result_sequencer
    import ars_pkg::*;
#(
    parameter int RES_W = 10 // converter result width
)
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // converter core
    output logic                  conv_start,
    output logic                  conv_abort,
    output logic                  conv_hold,
    input  wire logic             conv_done,
    input  wire logic [RES_W-1:0] conv_result,
    // triggers and debug
    input  wire logic             ext_trigger,
    input  wire logic             freeze_req,
    // interrupt
    output logic                  irq
);

    // refuse widths that do not fit the 16 low bits of a result word;
    // a wider converter would need two bus words per result register
    // and a second read to build one sample
    if (RES_W < 1 || RES_W > 16)
    begin : g_width_check
        $error("ars: RES_W must be 1 to 16");
    end

    // whole state of the block; one struct keeps every flop under a
    // single reset and a single next-state process, at the cost of a
    // wide comb block that recomputes all fields each cycle
    typedef struct packed
    {
        logic [ARS_NUM_CTL-1:0][7:0]          ctl;    // control registers
        logic [ARS_NUM_RESULT-1:0][RES_W-1:0] result; // result file
        logic [ARS_NUM_RESULT-1:0]            ccf;    // complete flags
        logic [2:0]                           cc;     // conversion_counter
        logic [2:0]                           idx;    // place in sequence
        ars_state_t                           st;     // sequencer state
        logic [ARS_NUM_EV-1:0]                ist;    // sticky events
        logic [ARS_NUM_EV-1:0]                imask;  // event mask
        logic [31:0]                          rdata;  // read data
    } ars_reg_t;

    ars_reg_t r;       // registered state
    ars_reg_t next_r;  // next state

    // decode sequence length field into a conversion count;
    // zero and any code with the top bit set both mean a full pass
    // over the result file, so the count never exceeds its depth
    function automatic logic [3:0] seq_len(input logic [7:0] sc);
        logic [3:0] code;
        code = sc[ARS_LEN_TOP:ARS_LEN_LO];
        if (code == 4'h0 || code[3])                     // R6
            seq_len = ARS_LEN_FULL;
        else
            seq_len = code;                              // R6
    endfunction : seq_len

    // true for an address inside the six control registers;
    // they sit word aligned at the bottom of the map
    function automatic logic is_ctl(input logic [7:0] a);
        is_ctl = (a[1:0] == 2'h0) && (a <= ARS_OFF_CTL_LAST);
    endfunction : is_ctl

    // bus phase qualifiers and decoded control fields,
    // taken from the registered control words, never from pwdata
    logic       setup_ph;   // first cycle of a transfer
    logic       wr_acc;     // write takes effect now
    logic       mapped;     // address hits a register
    logic [7:0] seq_ctl;    // sequence_control shorthand
    logic [1:0] frz_sel;    // freeze_select field
    logic       fifo_mode;  // result fifo mode
    logic       scan_mode;  // continuous scan
    logic       frz_now;    // immediate freeze in force
    logic       frz_stop;   // no new conversion may start
    logic [2:0] last_idx;   // index of the last conversion

    // field extraction and freeze decisions
    always_comb
    begin
        setup_ph  = psel && !penable;
        wr_acc    = psel && penable && pwrite;
        mapped    = is_ctl(paddr)
                    || paddr == ARS_OFF_STATUS
                    || paddr == ARS_OFF_IRQ_STAT
                    || paddr == ARS_OFF_IRQ_MASK
                    || paddr == ARS_OFF_CCF
                    || (paddr[7:5] == ARS_RESULT_PAGE && paddr[1:0] == 2'h0);
        // sequence_control is the fourth control word
        seq_ctl   = r.ctl[ARS_OFF_SEQ_CTL[4:2]];
        frz_sel   = {seq_ctl[ARS_FRZ_HI], seq_ctl[ARS_FRZ_LO]};
        fifo_mode = seq_ctl[ARS_FIFO_BIT];
        // scan restarts the sequence without software help
        scan_mode = r.ctl[ARS_CTL_LAST][ARS_SCAN_BIT];
        // freeze only acts while the debug request is up
        frz_now   = freeze_req && (frz_sel == ARS_FRZ_NOW);      // R9 R7
        // finish-then-freeze lets the running conversion end but
        // blocks the next launch; reserved code behaves as continue
        frz_stop  = freeze_req
                    && (frz_sel == ARS_FRZ_FINISH
                        || frz_sel == ARS_FRZ_NOW);              // R9 R7
        // a count of eight becomes index seven, still three bits wide
        last_idx  = 3'(seq_len(seq_ctl) - 4'h1);                 // R6
    end

    // handshake outputs toward the core and the bus
    always_comb
    begin
        // one start per launch; a control write in the same cycle
        // aborts instead, so the core never sees start and abort
        // together and a relaunch cannot stretch the start pulse
        conv_start = (r.st == ARS_LAUNCH) && !frz_stop
                     && !(wr_acc && is_ctl(paddr));
        // a control write while busy kills the conversion in flight
        conv_abort = wr_acc && is_ctl(paddr) && (r.st != ARS_IDLE);
        // immediate freeze pauses the core mid-conversion; the core
        // keeps its partial conversion while held
        conv_hold  = frz_now && (r.st == ARS_CONV);              // R7
        // zero wait states: every register answers at once
        pready     = 1'b1;
        // unmapped words answer with an error and read as zero
        pslverr    = psel && penable && !mapped;
        prdata     = r.rdata;
        // level interrupt straight from the sticky and mask flops
        irq        = |(r.ist & r.imask);
    end

    // next state: sequencer, result placement, registers, read data
    always_comb
    begin
        logic [ARS_NUM_EV-1:0] ev;   // events raised this cycle
        logic [2:0]            ri;   // result index being read
        // defaults first so every path assigns every field
        ev     = '0;
        ri     = paddr[4:2];
        next_r = r;

        // sequencer
        // one conversion outstanding at a time
        unique case (r.st)
            ARS_IDLE:
            begin
                // external trigger starts a sequence when enabled;
                // software starts come through the control write below
                if (ext_trigger
                    && r.ctl[ARS_OFF_TRIG_CTL[4:2]][ARS_EXTERNAL_TRIGGER_ENABLE_BIT])
                begin
                    next_r.idx = 3'h0;
                    // fifo keeps the counter so results go on filling
                    if (!fifo_mode)
                        next_r.cc = 3'h0;                        // R1
                    next_r.st = ARS_LAUNCH;                      // R2
                end
            end
            ARS_LAUNCH:
            begin
                // conv_start is raised toward the core in this state;
                // freeze holds the launch until the request drops
                if (!frz_stop)
                    next_r.st = ARS_CONV;
            end
            ARS_CONV:
            begin
                // a done pulse outside this state is ignored; a held
                // conversion simply waits here for its done pulse
                if (conv_done)
                begin
                    // result lands where the counter points
                    next_r.result[r.cc] = conv_result;           // R1 R2
                    next_r.ccf[r.cc]    = 1'b1;
                    ev[ARS_EV_CONV]     = 1'b1;
                    // 3-bit counter wraps past the last register
                    next_r.cc  = 3'(r.cc + 3'h1);                // R2 R3
                    next_r.idx = 3'(r.idx + 3'h1);
                    // last conversion of the sequence: event and decide
                    if (r.idx == last_idx)
                    begin
                        ev[ARS_EV_SEQ] = 1'b1;
                        next_r.idx     = 3'h0;
                        // non-fifo starts every sequence at register zero
                        if (!fifo_mode)
                            next_r.cc = 3'h0;                    // R1
                        next_r.st = scan_mode ? ARS_LAUNCH : ARS_IDLE;
                    end
                    else
                    begin
                        // more conversions to go in this sequence
                        next_r.st = ARS_LAUNCH;
                    end
                end
            end
        endcase

        // control write aborts and clears the counter, fifo or not;
        // it comes after the sequencer so that the write always wins
        if (wr_acc && is_ctl(paddr))
        begin
            next_r.ctl[paddr[4:2]] = pwdata[7:0];
            next_r.cc  = 3'h0;                                   // R5
            next_r.idx = 3'h0;                                   // R5
            next_r.st  = ARS_IDLE;
            // writing conversion_start_control launches a new sequence
            if (paddr == ARS_OFF_CTL_LAST)
                next_r.st = ARS_LAUNCH;                          // R5
        end

        // mask register; a masked event stays sticky, so unmasking
        // later raises the interrupt at once
        if (wr_acc && paddr == ARS_OFF_IRQ_MASK)
            next_r.imask = pwdata[ARS_NUM_EV-1:0];

        // complete flags: w1c, a new result in the same cycle wins;
        // software polls these to see which registers hold fresh data
        if (wr_acc && paddr == ARS_OFF_CCF)
            next_r.ccf = next_r.ccf & ~(pwdata[ARS_NUM_RESULT-1:0])
                         | (r.st == ARS_CONV && conv_done
                            ? 8'(8'h01 << r.cc) : 8'h00);

        // sticky events: w1c, set wins over clear;
        // an event in the clearing cycle survives, so none is lost
        if (wr_acc && paddr == ARS_OFF_IRQ_STAT)
            next_r.ist = (r.ist & ~pwdata[ARS_NUM_EV-1:0]) | ev;
        else
            next_r.ist = r.ist | ev;

        // read data captured in setup, shown during access;
        // writes and unmapped words leave zero in the capture
        if (setup_ph)
        begin
            next_r.rdata = 32'h0000_0000;
            if (!pwrite)
            begin
                if (is_ctl(paddr))
                    next_r.rdata[7:0] = r.ctl[paddr[4:2]];
                else if (paddr == ARS_OFF_STATUS)
                begin
                    // counter names the register the next result fills
                    next_r.rdata[ARS_ST_CC_LO +: 3] = r.cc;      // R4
                    next_r.rdata[ARS_ST_BUSY]       = r.st != ARS_IDLE;
                    next_r.rdata[ARS_ST_FROZEN]     = conv_hold
                        || (r.st == ARS_LAUNCH && frz_stop);
                end
                else if (paddr == ARS_OFF_IRQ_STAT)
                    next_r.rdata[ARS_NUM_EV-1:0] = r.ist;
                else if (paddr == ARS_OFF_IRQ_MASK)
                    next_r.rdata[ARS_NUM_EV-1:0] = r.imask;
                else if (paddr == ARS_OFF_CCF)
                    next_r.rdata[ARS_NUM_RESULT-1:0] = r.ccf;
                // results read back zero extended to the word
                else if (paddr[7:5] == ARS_RESULT_PAGE
                         && paddr[1:0] == 2'h0)
                    next_r.rdata[RES_W-1:0] = r.result[ri];
            end
        end
    end

    // state register, constants only under reset;
    // the struct clear covers every field without its own reset value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r       <= '0;
            r.ctl   <= {ARS_NUM_CTL{ARS_CTL_RST}};
            r.st    <= ARS_IDLE;
            r.imask <= ARS_MASK_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

endmodule : ars_adc_result_sequencer

`default_nettype wire

// >>> dv/ars_props.sv
// ars_props: port-level assertions for the result sequencer.
// assumes it is bound into ars_adc_result_sequencer; apb runs zero wait.
`timescale 1ns/100ps
`default_nettype none

module ars_props
    import ars_pkg::*;
#(
    parameter int RES_W = 10 // converter result width
)
(
    // clock, reset and apb
    input wire logic             pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata, prdata,
    input wire logic             pready, pslverr,
    // converter core, triggers, interrupt
    input wire logic             conv_start, conv_abort, conv_hold, conv_done,
    input wire logic [RES_W-1:0] conv_result,
    input wire logic             ext_trigger, freeze_req, irq
);
    wire logic acc = psel & penable; // access phase
    wire logic wr  = acc & pwrite;   // write taking effect

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a launch never stretches past one cycle
    property p_one; conv_start |=> !conv_start; endproperty
    a_one: assert property (p_one) else $error("start longer than one");
    // start register write launches next cycle unless frozen
    property p_launch; wr && paddr == ARS_OFF_CTL_LAST ##1 !freeze_req
        |-> conv_start; endproperty
    a_launch: assert property (p_launch) else $error("no launch");
    property p_abort; conv_abort |-> wr && paddr <= ARS_OFF_CTL_LAST;
        endproperty
    a_abort: assert property (p_abort) else $error("stray abort");
    // hold only while the breakpoint request stands
    property p_hold; conv_hold |-> freeze_req; endproperty
    a_hold: assert property (p_hold) else $error("hold unrequested");
    property p_hold_start; conv_hold |-> !conv_start; endproperty
    a_hold_start: assert property (p_hold_start)
        else $error("start in hold");
    // register words up to the complete flags answer without error, an unmapped one with error and 0
    property p_ok; acc && paddr <= ARS_OFF_CCF && paddr[1:0] == 2'h0
        |-> pready && !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("error on mapped word");
    property p_bad; acc && !pwrite && paddr == 8'h30
        |-> pslverr && prdata == 32'h0; endproperty
    a_bad: assert property (p_bad) else $error("unmapped read not refused");
    // read data stands until the next setup cycle
    property p_stand; acc |=> (psel && !penable) || $stable(prdata);
        endproperty
    a_stand: assert property (p_stand) else $error("read data moved");
endmodule : ars_props

bind ars_adc_result_sequencer ars_props #(.RES_W(RES_W)) u_props (.*);

`default_nettype wire

// >>> dv/tb.sv
// tb: register-level tests of the result sequencer over apb.
// assumes a core answers each start 5 cycles later, pausing on hold.
`timescale 1ns/100ps
`default_nettype none

module tb
    import ars_pkg::*;
    ;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic        conv_done = 0, ext_trigger = 0, freeze_req = 0, er;
    logic [9:0]  conv_result = 10'h000, nconv = 10'h000; // nconv: count
    logic [2:0]  cnt = 3'h0;                  // core cycles left
    logic [3:0]  lens [6] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'h8, 4'hF};
    logic [31:0] fexp [4] = '{32'h3, 32'h3, 32'h1, 32'h0};
    logic [31:0] sexp [4] = '{32'h0, 32'h0, 32'h19, 32'h18}; // frozen status
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, conv_start, conv_abort, conv_hold, irq;
    int          n_fail = 0, compares = 0, b, n;

    ars_adc_result_sequencer dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_start(conv_start), .conv_abort(conv_abort),
        .conv_hold(conv_hold), .conv_done(conv_done),
        .conv_result(conv_result), .ext_trigger(ext_trigger),
        .freeze_req(freeze_req), .irq(irq));

    initial forever #20 pclk = ~pclk;

    // core stand-in; result line scrambles outside the done cycle
    always @(posedge pclk)
    begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result;
        if (conv_abort) cnt <= 3'h0;
        else if (conv_start) cnt <= 3'h4;
        else if (cnt != 3'h0 && !conv_hold) cnt <= cnt - 3'h1;
        if (cnt == 3'h1 && !conv_hold && !conv_abort)
        begin
            conv_done <= 1'b1;
            conv_result <= 10'h100 + nconv;
            nconv <= nconv + 10'h1;
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // one apb transfer; holds until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk

    // poll status until the sequence has ended, bounded
    task automatic wait_idle;
        int i;
        i = 0;
        do
        begin
            apb(1'b0, ARS_OFF_STATUS, 32'h0);
            i++;
        end
        while (rd[ARS_ST_BUSY] !== 1'b0 && i < 200);
    endtask : wait_idle

    task automatic complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) rchk(8'(4 * i), 32'h0);
        rchk(8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test reset done");
        for (int k = 0; k < 6; k++)
        begin
            n = (lens[k] == 4'h0 || lens[k][3]) ? 8 : int'(lens[k]);
            apb(1'b1, ARS_OFF_SEQ_CTL, {25'h0, lens[k], 3'h0});
            apb(1'b1, ARS_OFF_CCF, 32'hFF);
            b = nconv;
            apb(1'b1, ARS_OFF_CTL_LAST, 32'h0);
            wait_idle;
            rchk(ARS_OFF_CCF, (32'h1 << n) - 32'h1);
            rchk(ARS_OFF_RESULT + 8'(4 * n - 4), 32'(255 + b + n));
            rchk(ARS_OFF_STATUS, 32'h0);
        end
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ARS_OFF_IRQ_MASK, 32'h1);
        rchk(ARS_OFF_IRQ_STAT, 32'h3);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ARS_OFF_IRQ_STAT, 32'h1);
        rchk(ARS_OFF_IRQ_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        $display("test length and irq done");
        // fifo with external trigger; three conversions each
        apb(1'b1, ARS_OFF_TRIG_CTL, 32'h1);
        apb(1'b1, ARS_OFF_SEQ_CTL, 32'h1C);
        for (int k = 1; k < 4; k++)
        begin
            ext_trigger <= 1'b1;
            @(posedge pclk);
            ext_trigger <= 1'b0;
            wait_idle;
            rchk(ARS_OFF_STATUS, 32'((3 * k) % 8));
        end
        // fifo with continuous scan
        apb(1'b1, ARS_OFF_CTL_LAST, 32'h20);
        repeat (40) @(posedge pclk);
        apb(1'b1, ARS_OFF_CTL0, 32'h0);
        rchk(ARS_OFF_STATUS, 32'h0);
        apb(1'b1, ARS_OFF_CCF, 32'hFF);
        b = nconv;
        apb(1'b1, ARS_OFF_CTL_LAST, 32'h0);
        wait_idle;
        rchk(ARS_OFF_RESULT, 32'(256 + b));
        $display("test fifo done");
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, ARS_OFF_SEQ_CTL, 32'h10 | c);
            apb(1'b1, ARS_OFF_CCF, 32'hFF);
            apb(1'b1, ARS_OFF_CTL_LAST, 32'h0);
            @(posedge pclk);
            freeze_req <= 1'b1;
            repeat (30) @(posedge pclk);
            rchk(ARS_OFF_CCF, fexp[c]);
            rchk(ARS_OFF_STATUS, sexp[c]);
            freeze_req <= 1'b0;
            wait_idle;
            rchk(ARS_OFF_CCF, 32'h3);
        end
        $display("test freeze done");
        complete_run;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        complete_run;
    end
endmodule : tb

`default_nettype wire
